// File: srlb_consts.svh
// Constants for the set-reset latch bank.
// Assumes inclusion by bare name from design files.
`ifndef SRLB_CONSTS_SVH
`define SRLB_CONSTS_SVH
`define SRLB_CHANNELS 8
`define SRLB_RESET_CANCEL 1'h0
`define SRLB_RESET_CLEAR 1'h1
`define SRLB_OUT_RESET 8'h00
`endif

// File: srlb_pkg.sv
// Types for the set-reset latch bank.
// Assumes srlb_consts.svh is on the include path.
`include "srlb_consts.svh"
package srlb_pkg;
    typedef logic [`SRLB_CHANNELS-1:0] srlb_vec_t;
    // Latch inputs travel together
    typedef struct packed {
        srlb_vec_t setIn;
        srlb_vec_t resetIn;
    } srlb_drive_t;
    // Nonvolatile store handshake phases
    typedef enum logic [1:0] {
        SRLB_RESTORE = 2'b00,
        SRLB_RUN = 2'b01
    } srlb_phase_t;
endpackage

// File: set_reset_latch_bank.sv
// Eight set-dominant set-reset latches with nonvolatile state.
// Assumes a nonvolatile store outside that returns the saved image after power-up.
// Assumes clear settings arrive as one-cycle pulses from the settings logic.
//
// Function
// RQ1: Eight independent latches, no cross coupling.
// RQ2: Set and reset both high gives 1.
// RQ3: Both inputs low keeps stored value.
// RQ4: Reset alone clears output to 0.
// RQ5: Set alone drives output to 1.
// RQ6: State saved to and restored from nonvolatile.
// RQ7: Per-channel reset setting clears only that channel.
// RQ8: Unconnected inputs are tied to 0.
// RQ9: Setting clear is one event, set blocks it.
`timescale 1ns/1ps
`include "srlb_consts.svh"
module set_reset_latch_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Latch inputs, tie unused bits to 0
    input wire srlb_pkg::srlb_drive_t drive,
    // Operator clear setting, one pulse per command
    input wire srlb_pkg::srlb_vec_t clearCmd,
    // Nonvolatile store
    input wire logic nvValid,
    input wire srlb_pkg::srlb_vec_t nvData,
    output logic nvWrite,
    output srlb_pkg::srlb_vec_t nvWriteData,
    // Latch outputs
    output srlb_pkg::srlb_vec_t latchOut
);
    // ----------------------------------------
    // Restore phase
    // ----------------------------------------
    srlb_pkg::srlb_phase_t phase_q;
    srlb_pkg::srlb_vec_t out_q;
    srlb_pkg::srlb_vec_t out_d;

    function automatic logic next_bit(input logic s, input logic r, input logic c, input logic q);
        // Set wins over both reset sources
        if (s)
            next_bit = 1'b1; // [RQ2] [RQ5] [RQ9]
        else if (r || c)
            next_bit = 1'b0; // [RQ4] [RQ7]
        else
            next_bit = q; // [RQ3]
    endfunction

    // Clear setting decode, shared by the latch and its checks
    function automatic logic clear_hit(input logic c);
        clear_hit = (c == `SRLB_RESET_CLEAR); // [RQ7]
    endfunction

    // Outputs stay cleared until the image is back, so no half state leaks out
    always_ff @(posedge mclk)
    begin
        if (!resetn)
            phase_q <= srlb_pkg::SRLB_RESTORE;
        else if (nvValid)
            phase_q <= srlb_pkg::SRLB_RUN;
    end

    // ----------------------------------------
    // Latch array
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < `SRLB_CHANNELS; i++)
        begin : gCh
            // Each bit sees only its own inputs
            assign out_d[i] = next_bit(drive.setIn[i], drive.resetIn[i],
                                       clear_hit(clearCmd[i]), out_q[i]); // [RQ1] [RQ8]
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (!resetn)
            out_q <= `SRLB_OUT_RESET;
        else
        begin
            case (phase_q)
                srlb_pkg::SRLB_RESTORE:
                begin
                    // Inputs are ignored until the saved image is back
                    if (nvValid)
                        out_q <= nvData; // [RQ6]
                end
                srlb_pkg::SRLB_RUN: out_q <= out_d;
                default: out_q <= `SRLB_OUT_RESET;
            endcase
        end
    end

    // ----------------------------------------
    // Store write-back
    // ----------------------------------------
    // Write only on change to spare store endurance
    // Image and pulse leave together so the store never takes a torn word
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            nvWrite <= 1'b0;
            nvWriteData <= `SRLB_OUT_RESET;
        end
        else
        begin
            nvWrite <= (phase_q == srlb_pkg::SRLB_RUN) && (out_d != out_q); // [RQ6]
            nvWriteData <= out_d;
        end
    end

    assign latchOut = out_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Latch checks wait for run mode; restore has its own set below
    logic running;
    assign running = (phase_q == srlb_pkg::SRLB_RUN);

    generate
        for (i = 0; i < `SRLB_CHANNELS; i++)
        begin : gChk
            sequence setSeen;
                running && drive.setIn[i];
            endsequence
            sequence quietSeen;
                running && !drive.setIn[i] && !drive.resetIn[i] && !clearCmd[i];
            endsequence
            sequence resetSeen;
                running && drive.resetIn[i] && !drive.setIn[i];
            endsequence
            sequence clearSeen;
                running && clear_hit(clearCmd[i]) && !drive.setIn[i];
            endsequence
            sequence runSteady;
                running && $past(running);
            endsequence

            set_wins_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ2]
                setSeen and drive.resetIn[i] |=> latchOut[i]) else $error("set did not win");
            set_alone_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ5]
                setSeen |=> latchOut[i] == 1'b1) else $error("set not latched");
            hold_state_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ3]
                quietSeen |=> $stable(latchOut[i])) else $error("latch drifted");
            reset_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ4]
                running && drive.resetIn[i] && !drive.setIn[i] |=> !latchOut[i]) else $error("reset failed");
            cmd_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ7]
                running && clearCmd[i] && !drive.setIn[i] |=> !latchOut[i]) else $error("clear failed");
            cmd_blocked_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ9]
                running && clearCmd[i] && drive.setIn[i] |=> latchOut[i]) else $error("clear beat set");
            // Next value from this channel's own inputs only, so any coupling shows
            channel_isolate_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ1]
                running |=> latchOut[i] == ($past(drive.setIn[i])
                    || ($past(latchOut[i]) && !$past(drive.resetIn[i]) && !$past(clearCmd[i]))))
                else $error("channel coupled");
            input_tie_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ8]
                running && !drive.setIn[i] && !latchOut[i] |=> !latchOut[i]) else $error("phantom set");

            // Two-step checks: the new value must also survive a quiet cycle
            set_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ5]
                setSeen ##1 quietSeen |=> latchOut[i]) else $error("set not held");
            reset_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ4]
                resetSeen ##1 quietSeen |=> !latchOut[i]) else $error("reset not held");
            clear_once_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ9]
                clearSeen ##1 quietSeen |=> !latchOut[i]) else $error("clear not held");

            // A change in run mode always has a cause on this channel
            rise_cause_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ5]
                runSteady and $rose(latchOut[i]) |-> $past(drive.setIn[i])) else $error("rise without set");
            fall_cause_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ4] [RQ7]
                runSteady and $fell(latchOut[i]) |-> !$past(drive.setIn[i])
                    && ($past(drive.resetIn[i]) || $past(clear_hit(clearCmd[i]))))
                else $error("fall without clear");
        end
    endgenerate

    // ----------------------------------------
    // Restore and store checks
    // ----------------------------------------
    // Power return runs in steps: image offered, image shown, run mode kept
    sequence imageOffered;
        !running && nvValid;
    endsequence
    sequence imageWaiting;
        !running && !nvValid;
    endsequence
    sequence imageChanged;
        running && out_d != out_q;
    endsequence
    sequence imageKept;
        running && out_d == out_q;
    endsequence
    sequence bankQuiet;
        running && drive.setIn == '0 && drive.resetIn == '0 && clearCmd == '0;
    endsequence

    restore_load_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        imageOffered |=> latchOut == $past(nvData) ##1 running) else $error("restore wrong");
    restore_refuse_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        imageWaiting |=> $stable(latchOut)) else $error("input seen before restore");
    restore_nowrite_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        !running |=> !nvWrite) else $error("write before restore");
    run_sticky_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        running |=> running) else $error("run mode lost");

    store_write_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        imageChanged |=> nvWrite && nvWriteData == latchOut) else $error("store missed");
    store_quiet_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        imageKept |=> !nvWrite) else $error("needless store write");
    store_match_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ6]
        nvWrite |-> nvWriteData == latchOut) else $error("store image stale");
    bank_quiet_a: assert property (@(posedge mclk) disable iff (!resetn) // [RQ3]
        bankQuiet |=> $stable(latchOut) && !nvWrite) else $error("quiet bank changed");

    // Power loss empties the outputs until the image is back
    reset_zero_a: assert property (@(posedge mclk) // [RQ6]
        !resetn |=> latchOut == `SRLB_OUT_RESET && !nvWrite && !running) else $error("reset left state");
endmodule // set_reset_latch_bank

// File: srlb_nv_store.sv
// Nonvolatile store model for the latch bank.
// Assumes one mclk domain, sync active-low reset.
`timescale 1ns/1ps
module srlb_nv_store #(parameter int LAT = 3) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Store ports
    output logic nvValid,
    output srlb_pkg::srlb_vec_t nvData,
    input wire logic nvWrite,
    input wire srlb_pkg::srlb_vec_t nvWriteData
);
    srlb_pkg::srlb_vec_t img_q = 8'h00;
    logic [3:0] cnt_q = 4'h0;
    always @(posedge mclk)
        if (nvWrite) img_q <= nvWriteData;
    always @(posedge mclk)
        if (!resetn) cnt_q <= 4'h0;
        else if (cnt_q <= LAT) cnt_q <= cnt_q + 4'h1;
    assign nvValid = (cnt_q == LAT);
    // Not valid: inverted image, so a stray sample is seen
    assign nvData = nvValid ? img_q : ~img_q;
endmodule // srlb_nv_store

// File: tb.sv
// Self-checking bench for the latch bank.
// Assumes srlb_consts.svh on the include path.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    srlb_pkg::srlb_drive_t drive = '0;
    srlb_pkg::srlb_vec_t clearCmd = 8'h00;
    srlb_pkg::srlb_vec_t nvData, nvWriteData, latchOut;
    logic nvValid, nvWrite;
    logic [7:0] expQ = 8'h00;
    logic [7:0] b;
    int n_fail = 0;
    int total_checks = 0;
    always #5 mclk = ~mclk;
    set_reset_latch_bank i_set_reset_latch_bank (.mclk(mclk), .resetn(resetn), .drive(drive),
        .clearCmd(clearCmd), .nvValid(nvValid), .nvData(nvData), .nvWrite(nvWrite),
        .nvWriteData(nvWriteData), .latchOut(latchOut));
    srlb_nv_store i_srlb_nv_store (.mclk(mclk), .resetn(resetn), .nvValid(nvValid), .nvData(nvData),
        .nvWrite(nvWrite), .nvWriteData(nvWriteData));
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic step(input logic [7:0] s, input logic [7:0] r, input logic [7:0] c);
        logic [7:0] nxt;
        drive <= '{setIn: s, resetIn: r};
        clearCmd <= c;
        @(posedge mclk);
        #1;
        nxt = s | (expQ & ~r & ~c);
        `CHK("latchOut", nxt, latchOut)
        `CHK("nvWrite", nxt != expQ, nvWrite)
        if (nxt != expQ)
            `CHK("nvWriteData", nxt, nvWriteData)
        expQ = nxt;
    endtask
    // Power loss: outputs drop, then the stored image returns
    task automatic powerUp();
        int k;
        resetn <= 1'b0;
        drive <= '0;
        clearCmd <= 8'h00;
        repeat (4) @(posedge mclk);
        #1;
        `CHK("latchOut", 8'h00, latchOut)
        resetn <= 1'b1;
        // Inputs are refused until the image is back
        drive <= '{setIn: 8'($urandom), resetIn: 8'($urandom)};
        clearCmd <= 8'($urandom);
        for (k = 0; k < 20 && nvValid !== 1'b1; k++)
            @(posedge mclk) #1;
        if (k == 20)
        begin
            n_fail++;
            summarize();
        end
        else
        begin
            @(posedge mclk);
            #1;
            `CHK("restore", expQ, latchOut)
        end
    endtask
    initial
    begin
        void'($urandom(32'h5f57a2a9));
        powerUp();
        for (int ch = 0; ch < 8; ch++)
        begin
            b = 8'h01 << ch;
            step(b, 8'h00, 8'h00);
            step(8'h00, 8'h00, 8'h00);
            step(b, b, 8'h00);
            step(b, 8'h00, b);
            step(8'h00, b, 8'h00);
            step(b, 8'h00, 8'h00);
            step(8'h00, 8'h00, b);
            step(8'h00, 8'h00, 8'h00);
        end
        for (int i = 0; i < 400; i++)
        begin
            // Sparse patterns keep state alive between events
            step(8'($urandom & $urandom), 8'($urandom & $urandom), 8'($urandom & $urandom & $urandom));
            if (i == 200)
                powerUp();
        end
        summarize();
    end
endmodule // tb
